/* design/dfc_pkg.sv */
// Package for the DRAM frequency change and write leveling sequencer
package dfc_pkg;
   // Register byte offsets
   localparam logic [7:0] DFC_REG_CTRL   = 8'h00;
   localparam logic [7:0] DFC_REG_STATUS = 8'h04;
   localparam logic [7:0] DFC_REG_TIME0  = 8'h08;
   localparam logic [7:0] DFC_REG_TIME1  = 8'h0c;
   localparam logic [7:0] DFC_REG_MODE   = 8'h10;
   localparam logic [7:0] DFC_REG_WLDLY  = 8'h14;
   // Control register fields
   localparam int DFC_CTRL_GO      = 0;
   localparam int DFC_CTRL_OP_LO   = 1;
   localparam int DFC_CTRL_OP_HI   = 2;
   localparam int DFC_CTRL_ODTEN   = 3;
   localparam int DFC_CTRL_CLKSTB  = 4;
   // Operation codes
   localparam logic [1:0] DFC_OP_ON2OFF = 2'h0;
   localparam logic [1:0] DFC_OP_OFF2ON = 2'h1;
   localparam logic [1:0] DFC_OP_PDCHG  = 2'h2;
   localparam logic [1:0] DFC_OP_WLEV   = 2'h3;
   // DRAM command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] DFC_CMD_NOP  = 4'h7;
   localparam logic [3:0] DFC_CMD_MRS  = 4'h0;
   localparam logic [3:0] DFC_CMD_REF  = 4'h1;
   localparam logic [3:0] DFC_CMD_ZQCL = 4'h6;
   // Mode register address bits
   localparam int DFC_MR1_DLL_DIS = 0;
   localparam int DFC_MR0_DLL_RST = 8;
   localparam int DFC_MR1_WLEV    = 7;
   // Reset values of wait counts in cycles, write leveling tap limit and step gap
   localparam logic [15:0] DFC_RST_WAIT = 16'h0010;
   localparam logic [15:0] DFC_RST_DLLK = 16'h0200;
   localparam logic [7:0]  DFC_WL_MAX   = 8'hff;
   localparam logic [3:0]  DFC_WL_GAP   = 4'hf;
   typedef enum logic [3:0] {
      DFC_IDLE = 4'h0, DFC_MR1A = 4'h1, DFC_SRE  = 4'h3, DFC_CKE  = 4'h2,
      DFC_CLK  = 4'h6, DFC_SRX  = 4'h7, DFC_MR1B = 4'h5, DFC_MR0  = 4'h4,
      DFC_MRX  = 4'hc, DFC_ZQ   = 4'hd, DFC_LOCK = 4'hf, DFC_WLP  = 4'he,
      DFC_WLS  = 4'ha, DFC_DONE = 4'hb
   } dfc_state_t;
endpackage

/* design/dfc_seq.sv */
// Controller-side DLL switch, clock change and write leveling sequencer
//
// Operation
// - DLL-on to off: idle, RTT off, MR1 A0=1, self-refresh, change clock, rewrite.
// - DLL-off to on starts idle, banks precharged, termination off, then self-refresh.
// - Wait tCKSRE after self-refresh entry before changing the clock.
// - Hold new clock stable tCKSRX before self-refresh exit.
// - Keep CKE high from self-refresh exit until tDLLK after DLL reset.
// - ODT low until tDLLK after DLL reset when termination was enabled.
// - After exit wait tXS, then MR1 A0=0 enables the DLL.
// - Wait tMRD, then MR0 A8=1 starts DLL reset.
// - After further tMRD program mode registers; ZQCL allowed after tMOD.
// - Wait tMOD, tDLLK after reset, and tZQoper after ZQCL.
// - Change clock only in self-refresh or precharge power-down.
// - Below minimum frequency use DLL-on to DLL-off sequence.
// - In power-down ODT low when nominal termination was enabled.
// - In power-down wait tCKSRE after CKE low before clock change.
// - During power-down clock change keep ODT and CKE low.
// - Stable clock tCKSRX before power-down exit; after tXP reset DLL.
// - During relock ODT low, CKE high; mode writes with CKE high.
// - New clock frequency stays within speed grade limits.
// - Step strobe delay until feedback goes 0 to 1, then keep it.
// - Provide adjustable per-strobe delay to align strobe with clock.
// - Only deselect or NOP during tXS after self-refresh exit.
// - Enter self-refresh only with all banks idle.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module dfc_seq
   import dfc_pkg::*;
#(
   parameter int WL_W = 8
) (
   // Clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // DRAM side
   output logic             dram_cke,
   output logic             dram_odt,
   output logic [3:0]       dram_cmd,
   output logic [2:0]       dram_ba,
   output logic [15:0]      dram_addr,
   output logic             clk_change_ok,
   output logic [WL_W-1:0]  dqs_delay,
   output logic             dqs_pulse,
   input  wire logic        wl_feedback
);

   typedef struct packed {
      dfc_state_t  st;
      logic [15:0] cnt;
      logic [1:0]  op;
      logic        odt_en, busy, done, wl_fail;
      logic        prev_fb, fb_m, fb_s, clk_stb_m, clk_stb_s;
      logic [15:0] t_short, t_long, t_dllk, t_zq, mr_val;
      logic        cke, odt;
      logic [3:0]  cmd;
      logic [2:0]  ba;
      logic [15:0] addr;
      logic        chg_ok;
      logic [WL_W-1:0] dly;
      logic        pulse;
      logic        awr, wr, bv, arr, rv;
      logic [31:0] rd;
      logic        aw_got, w_got, w_strb0;
      logic [7:0]  aw_a;
      logic [31:0] w_d;
   } dfc_reg_t;

   dfc_reg_t r_ff;
   dfc_reg_t nxt_r;

   // Read data mux
   function automatic logic [31:0] dfc_rd(input dfc_reg_t s,
                                          input logic [7:0] a);
      if (a == DFC_REG_CTRL) begin
         dfc_rd = {27'h0, s.clk_stb_s, s.odt_en, s.op, 1'b0};
      end else if (a == DFC_REG_STATUS) begin
         dfc_rd = {20'h0, s.st, 4'h0, s.chg_ok, s.wl_fail, s.done, s.busy};
      end else if (a == DFC_REG_TIME0) begin
         dfc_rd = {s.t_long, s.t_short};
      end else if (a == DFC_REG_TIME1) begin
         dfc_rd = {s.t_zq, s.t_dllk};
      end else if (a == DFC_REG_MODE) begin
         dfc_rd = {16'h0, s.mr_val};
      end else if (a == DFC_REG_WLDLY) begin
         dfc_rd = {{(32-WL_W){1'b0}}, s.dly};
      end else begin
         dfc_rd = 32'h0;
      end
   endfunction

   // Next state
   always_comb begin
      logic wr_fire;
      logic start;
      logic cnt_zero;
      wr_fire  = 1'b0;
      start    = 1'b0;
      cnt_zero = (r_ff.cnt == 16'h0);
      nxt_r = r_ff;
      nxt_r.fb_m      = wl_feedback;
      nxt_r.fb_s      = r_ff.fb_m;
      nxt_r.clk_stb_m = r_ff.clk_stb_s;
      nxt_r.cmd   = DFC_CMD_NOP;
      nxt_r.pulse = 1'b0;
      if (!cnt_zero) begin
         nxt_r.cnt = r_ff.cnt - 16'h1;
      end

      // Write channel capture
      if (s_axi_awvalid && r_ff.awr) begin
         nxt_r.aw_got = 1'b1;
         nxt_r.aw_a   = s_axi_awaddr;
         nxt_r.awr    = 1'b0;
      end
      if (s_axi_wvalid && r_ff.wr) begin
         nxt_r.w_got = 1'b1;
         nxt_r.w_d   = s_axi_wdata;
         nxt_r.w_strb0 = s_axi_wstrb[0];
         nxt_r.wr    = 1'b0;
      end
      if (r_ff.aw_got && r_ff.w_got && !r_ff.bv) begin
         wr_fire     = 1'b1;
         nxt_r.bv    = 1'b1;
         nxt_r.aw_got = 1'b0;
         nxt_r.w_got  = 1'b0;
      end
      if (r_ff.bv && s_axi_bready) begin
         nxt_r.bv  = 1'b0;
         nxt_r.awr = 1'b1;
         nxt_r.wr  = 1'b1;
      end
      // Register writes, low byte lane only for control
      if (wr_fire) begin
         if (r_ff.aw_a == DFC_REG_CTRL && r_ff.w_strb0) begin
            start = r_ff.w_d[DFC_CTRL_GO] && !r_ff.busy;
            if (!r_ff.busy) begin
               nxt_r.op = r_ff.w_d[DFC_CTRL_OP_HI:DFC_CTRL_OP_LO];
               nxt_r.odt_en = r_ff.w_d[DFC_CTRL_ODTEN];
            end
            nxt_r.clk_stb_s = r_ff.w_d[DFC_CTRL_CLKSTB];
         end else if (r_ff.aw_a == DFC_REG_TIME0) begin
            nxt_r.t_short = r_ff.w_d[15:0];
            nxt_r.t_long  = r_ff.w_d[31:16];
         end else if (r_ff.aw_a == DFC_REG_TIME1) begin
            nxt_r.t_dllk = r_ff.w_d[15:0];
            nxt_r.t_zq   = r_ff.w_d[31:16];
         end else if (r_ff.aw_a == DFC_REG_MODE) begin
            nxt_r.mr_val = r_ff.w_d[15:0];
         end else if (r_ff.aw_a == DFC_REG_WLDLY && !r_ff.busy) begin
            nxt_r.dly = r_ff.w_d[WL_W-1:0];
         end
      end
      // Read channel
      if (s_axi_arvalid && r_ff.arr) begin
         nxt_r.arr = 1'b0;
         nxt_r.rv  = 1'b1;
         nxt_r.rd  = dfc_rd(r_ff, s_axi_araddr);
      end
      if (r_ff.rv && s_axi_rready) begin
         nxt_r.rv  = 1'b0;
         nxt_r.arr = 1'b1;
      end

      // Sequencer; every wait except the software clock strobe in DFC_CLK is a counter with NOP issued
      case (r_ff.st)
         DFC_IDLE: begin
            nxt_r.cke = 1'b1;
            nxt_r.odt = 1'b0; // Termination off before starting
            if (start) begin
               nxt_r.busy = 1'b1;
               nxt_r.done = 1'b0;
               nxt_r.wl_fail = 1'b0;
               nxt_r.cnt  = r_ff.t_short;
               if (nxt_r.op == DFC_OP_ON2OFF) begin
                  nxt_r.st = DFC_MR1A;
               end else if (nxt_r.op == DFC_OP_WLEV) begin
                  nxt_r.st = DFC_WLP;
                  nxt_r.cmd = DFC_CMD_MRS;
                  nxt_r.ba  = 3'h1;
                  nxt_r.addr = r_ff.mr_val | (16'h1 << DFC_MR1_WLEV);
                  nxt_r.dly = '0;
               end else begin
                  nxt_r.st = DFC_SRE;
               end
            end
         end
         DFC_MR1A: begin
            // DLL disable from idle with RTT off
            nxt_r.cmd  = DFC_CMD_MRS;
            nxt_r.ba   = 3'h1;
            nxt_r.addr = r_ff.mr_val | (16'h1 << DFC_MR1_DLL_DIS);
            nxt_r.cnt  = r_ff.t_short;
            nxt_r.st   = DFC_SRE;
         end
         DFC_SRE: if (cnt_zero) begin
            // Entry from all-banks-idle only
            nxt_r.cke = 1'b0;
            nxt_r.odt = 1'b0;
            nxt_r.cmd = (r_ff.op == DFC_OP_PDCHG) ? DFC_CMD_NOP : DFC_CMD_REF;
            nxt_r.cnt = r_ff.t_short;
            nxt_r.st  = DFC_CKE;
         end
         DFC_CKE: if (cnt_zero) begin
            // tCKSRE done: clock may now change
            nxt_r.chg_ok = 1'b1;
            nxt_r.st     = DFC_CLK;
         end
         DFC_CLK: if (r_ff.clk_stb_m) begin
            // Software signals new in-range clock
            nxt_r.chg_ok = 1'b0;
            nxt_r.cnt    = r_ff.t_short;
            nxt_r.st     = DFC_SRX;
         end
         DFC_SRX: if (cnt_zero) begin
            // tCKSRX satisfied, exit with NOP
            nxt_r.cke = 1'b1; // Held high from here
            nxt_r.odt = 1'b0;
            nxt_r.cnt = r_ff.t_long; // tXS or tXP, NOPs only
            nxt_r.st  = (r_ff.op == DFC_OP_PDCHG) ? DFC_MR0 : DFC_MR1B;
         end
         DFC_MR1B: if (cnt_zero) begin
            nxt_r.cmd  = DFC_CMD_MRS;
            nxt_r.ba   = 3'h1;
            nxt_r.addr = r_ff.mr_val;
            if (r_ff.op == DFC_OP_ON2OFF) begin
               nxt_r.addr = r_ff.mr_val | (16'h1 << DFC_MR1_DLL_DIS);
               nxt_r.cnt = r_ff.t_short;
               nxt_r.st  = DFC_DONE;
            end else begin
               nxt_r.addr = r_ff.mr_val & ~(16'h1 << DFC_MR1_DLL_DIS);
               nxt_r.cnt = r_ff.t_short; // tMRD
               nxt_r.st  = DFC_MR0;
            end
         end
         DFC_MR0: if (cnt_zero) begin
            nxt_r.cmd  = DFC_CMD_MRS; // DLL reset
            nxt_r.ba   = 3'h0;
            nxt_r.addr = r_ff.mr_val | (16'h1 << DFC_MR0_DLL_RST);
            nxt_r.cnt  = r_ff.t_short;
            nxt_r.st   = DFC_MRX;
         end
         DFC_MRX: if (cnt_zero) begin
            // Update CL, CWL, WR in MR2 with CKE high
            nxt_r.cmd  = DFC_CMD_MRS;
            nxt_r.ba   = 3'h2;
            nxt_r.addr = r_ff.mr_val;
            nxt_r.cnt  = r_ff.t_short; // tMOD
            nxt_r.st   = DFC_ZQ;
         end
         DFC_ZQ: if (cnt_zero) begin
            nxt_r.cmd = DFC_CMD_ZQCL; // After tMOD
            nxt_r.cnt = (r_ff.t_zq > r_ff.t_dllk) ? r_ff.t_zq : r_ff.t_dllk;
            nxt_r.st  = DFC_LOCK;
         end
         DFC_LOCK: if (cnt_zero) begin
            // tDLLK and tZQoper done
            nxt_r.st = DFC_DONE;
         end
         DFC_WLP: if (cnt_zero) begin
            nxt_r.pulse = 1'b1; // Single strobe edge
            nxt_r.cnt   = {12'h0, DFC_WL_GAP};
            nxt_r.prev_fb = r_ff.fb_s;
            nxt_r.st    = DFC_WLS;
         end
         DFC_WLS: if (cnt_zero) begin
            if (!r_ff.prev_fb && r_ff.fb_s) begin
               nxt_r.st = DFC_DONE; // Lock delay on 0 to 1
            end else if (r_ff.dly == WL_W'(DFC_WL_MAX)) begin
               nxt_r.wl_fail = 1'b1;
               nxt_r.st = DFC_DONE;
            end else begin
               nxt_r.prev_fb = r_ff.fb_s;
               nxt_r.dly = r_ff.dly + WL_W'(1); // Step delay
               nxt_r.pulse = 1'b1;
               nxt_r.cnt = {12'h0, DFC_WL_GAP};
            end
         end
         DFC_DONE: if (cnt_zero) begin
            if (r_ff.op == DFC_OP_WLEV) begin
               nxt_r.cmd  = DFC_CMD_MRS;
               nxt_r.ba   = 3'h1;
               nxt_r.addr = r_ff.mr_val & ~(16'h1 << DFC_MR1_WLEV);
            end
            nxt_r.busy = 1'b0;
            nxt_r.done = 1'b1;
            nxt_r.st   = DFC_IDLE;
         end
         default: nxt_r.st = DFC_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r_ff <= '{st: DFC_IDLE, cmd: DFC_CMD_NOP, awr: 1'b1, wr: 1'b1,
                   arr: 1'b1, t_short: DFC_RST_WAIT, t_long: DFC_RST_WAIT,
                   t_dllk: DFC_RST_DLLK, t_zq: DFC_RST_DLLK, default: '0};
      end else if (clk_en) begin
         r_ff <= nxt_r;
      end
   end

   // Outputs straight from flops, except s_axi_bresp and s_axi_rresp tied to zero
   assign s_axi_bresp   = 2'h0;
   assign s_axi_rresp   = 2'h0;
   assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready,
           s_axi_rvalid} = {r_ff.awr, r_ff.wr, r_ff.bv, r_ff.arr, r_ff.rv};
   assign s_axi_rdata   = r_ff.rd;
   assign {dram_cke, dram_odt, dram_cmd, dram_ba, dram_addr} =
          {r_ff.cke, r_ff.odt, r_ff.cmd, r_ff.ba, r_ff.addr};
   assign {clk_change_ok, dqs_delay, dqs_pulse} =
          {r_ff.chg_ok, r_ff.dly, r_ff.pulse};

   // Checks
   AST_CKE_LOW_CHG: assert property (@(posedge sys_clk) disable iff (reset)
      clk_change_ok |-> !dram_cke && !dram_odt)
      else $error("cke or odt high during clock change");
   AST_ODT_LOCK: assert property (@(posedge sys_clk) disable iff (reset)
      (r_ff.st == DFC_LOCK) |-> dram_cke && !dram_odt)
      else $error("cke low or odt high during relock");
   AST_NOP_WAIT: assert property (@(posedge sys_clk) disable iff (reset)
      (r_ff.st == DFC_MR1B && r_ff.cnt > 16'h1)
      |=> dram_cmd == DFC_CMD_NOP)
      else $error("command during exit wait");
   AST_SRE_BEFORE_CHG: assert property (@(posedge sys_clk)
      disable iff (reset)
      $rose(clk_change_ok) |-> $past(r_ff.st) == DFC_CKE)
      else $error("clock change allowed too early");
   AST_DLL_RST: assert property (@(posedge sys_clk) disable iff (reset)
      (dram_cmd == DFC_CMD_MRS && dram_ba == 3'h0 && r_ff.busy)
      |-> dram_addr[DFC_MR0_DLL_RST])
      else $error("mr0 write without dll reset");
   AST_ZQ_CKE: assert property (@(posedge sys_clk) disable iff (reset)
      (dram_cmd == DFC_CMD_ZQCL) |-> dram_cke && !dram_odt)
      else $error("zq issued with cke low");
   AST_WL_STEP: assert property (@(posedge sys_clk) disable iff (reset)
      (clk_en && r_ff.st == DFC_WLS && r_ff.cnt == 16'h0 && !r_ff.prev_fb
       && !r_ff.fb_s && r_ff.dly != WL_W'(DFC_WL_MAX))
      |=> dqs_delay == $past(dqs_delay) + WL_W'(1))
      else $error("strobe delay did not step");
   AST_SRX_CKE: assert property (@(posedge sys_clk) disable iff (reset)
      (clk_en && r_ff.st == DFC_SRX && r_ff.cnt == 16'h0) |=> dram_cke)
      else $error("cke not raised at exit");

endmodule

/* dv/dfc_dram_model.sv */
// Behavioural DRAM facing the sequencer: mode state, command watch, feedback
`timescale 1ns/1ns
module dfc_dram_model
   import dfc_pkg::*;
#(
   parameter int LOCK_TAP = 37
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Command pins
   input  wire logic        dram_cke,
   input  wire logic        dram_odt,
   input  wire logic [3:0]  dram_cmd,
   input  wire logic [2:0]  dram_ba,
   input  wire logic [15:0] dram_addr,
   // Strobe and feedback
   input  wire logic [7:0]  dqs_delay,
   input  wire logic        dqs_pulse,
   output logic             wl_feedback,
   // Observation
   output int               err_cnt,
   output int               sr_cnt,
   output int               zq_cnt,
   output int               rst_cnt,
   output logic             dll_off,
   output logic             wl_mode
);
   logic cke_q;

   // Decode commands, track modes, count illegal activity
   always @(posedge sys_clk) begin
      if (reset) begin
         err_cnt     <= 0;
         sr_cnt      <= 0;
         zq_cnt      <= 0;
         rst_cnt     <= 0;
         dll_off     <= 1'b0;
         wl_mode     <= 1'b0;
         cke_q       <= 1'b0;
         wl_feedback <= 1'b0;
      end else begin
         cke_q <= dram_cke;
         // Self-refresh entry on falling clock enable
         if (!dram_cke && cke_q && dram_cmd === DFC_CMD_REF)
            sr_cnt <= sr_cnt + 1;
         // Clock ignored while parked: only NOP accepted
         else if (dram_cke !== 1'b1 && dram_cmd !== DFC_CMD_NOP)
            err_cnt <= err_cnt + 1;
         if (dram_odt !== 1'b0)
            err_cnt <= err_cnt + 1;
         if (dram_cke && dram_cmd === DFC_CMD_MRS && dram_ba === 3'h1) begin
            dll_off <= dram_addr[DFC_MR1_DLL_DIS];
            wl_mode <= dram_addr[DFC_MR1_WLEV];
         end
         if (dram_cke && dram_cmd === DFC_CMD_MRS && dram_ba === 3'h0 &&
             dram_addr[DFC_MR0_DLL_RST])
            rst_cnt <= rst_cnt + 1;
         if (dram_cke && dram_cmd === DFC_CMD_ZQCL)
            zq_cnt <= zq_cnt + 1;
         // Clock level sampled on strobe, else undefined lines
         if (dram_cke && dram_cmd === DFC_CMD_MRS && dram_ba === 3'h1 &&
             dram_addr[DFC_MR1_WLEV])
            wl_feedback <= 1'b0;
         else if (wl_mode && dqs_pulse)
            wl_feedback <= (dqs_delay >= LOCK_TAP[7:0]);
         else if (!wl_mode)
            wl_feedback <= ~wl_feedback;
      end
   end
endmodule

/* dv/tb.sv */
// Register-level testbench of the DLL switch and clock change sequencer
`timescale 1ns/1ns
module tb
   import dfc_pkg::*;
;
   localparam int TAP = 37;
   logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0;
   logic awready, wready, bvalid, arready, rvalid, cke, odt, ok, pulse;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rd;
   logic [3:0] cmd;
   logic [2:0] ba;
   logic [15:0] addr;
   logic [7:0] dly;
   logic fb, dll_off, wl_mode;
   int err_cnt, sr_cnt, zq_cnt, rst_cnt, cyc = 0, fail_count = 0, n_tests = 0;
   int sr0, rst0, zq0;

   // Clock
   always #4 sys_clk = ~sys_clk;

   dfc_seq #(.WL_W(8)) i_dut (
      .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .dram_cke(cke), .dram_odt(odt),
      .dram_cmd(cmd), .dram_ba(ba), .dram_addr(addr),
      .clk_change_ok(ok), .dqs_delay(dly), .dqs_pulse(pulse),
      .wl_feedback(fb));

   dfc_dram_model #(.LOCK_TAP(TAP)) i_mem (
      .sys_clk(sys_clk), .reset(reset), .dram_cke(cke), .dram_odt(odt),
      .dram_cmd(cmd), .dram_ba(ba), .dram_addr(addr), .dqs_delay(dly),
      .dqs_pulse(pulse), .wl_feedback(fb), .err_cnt(err_cnt),
      .sr_cnt(sr_cnt), .zq_cnt(zq_cnt), .rst_cnt(rst_cnt),
      .dll_off(dll_off), .wl_mode(wl_mode));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // AXI4-Lite write: both channels offered, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) begin
            bready <= 1'b0;
            break;
         end
      end
   endtask

   // AXI4-Lite read
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) begin
            d = rdata;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // Poll a status bit until set
   task automatic poll(input int b);
      rd = '0;
      while (rd[b] !== 1'b1) axi_rd(DFC_REG_STATUS, rd);
   endtask

   // One sequencer operation, with the clock change acknowledged for all ops but write leveling
   task automatic run_op(input logic [1:0] op);
      sr0 = sr_cnt;
      rst0 = rst_cnt;
      zq0 = zq_cnt;
      axi_wr(DFC_REG_CTRL, {27'h0, 2'b00, op, 1'b1});
      if (op != DFC_OP_WLEV) begin
         poll(3);
         chk({31'h0, cke}, 32'h0);
         chk({31'h0, ok}, 32'h1);
         axi_wr(DFC_REG_CTRL, {27'h0, 1'b1, 1'b0, op, 1'b0});
      end
      poll(1);
      axi_rd(DFC_REG_STATUS, rd);
      chk({29'h0, rd[2:0]}, 32'h2);
      chk({31'h0, cke}, 32'h1);
      chk({31'h0, ok}, 32'h0);
      axi_wr(DFC_REG_CTRL, 32'h0);
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      // Clock enable low keeps all state frozen out of reset
      repeat (4) @(posedge sys_clk);
      chk({31'h0, cke}, 32'h0);
      clk_en <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk({31'h0, cke}, 32'h1);
      // Register access and unmapped space
      axi_wr(DFC_REG_TIME0, 32'h0020_0006);
      axi_rd(DFC_REG_TIME0, rd);
      chk(rd, 32'h0020_0006);
      axi_wr(DFC_REG_TIME1, 32'h0030_0040);
      axi_rd(DFC_REG_TIME1, rd);
      chk(rd, 32'h0030_0040);
      axi_wr(DFC_REG_CTRL, 32'h1c);
      axi_rd(DFC_REG_CTRL, rd);
      chk(rd, 32'h1c);
      axi_wr(DFC_REG_CTRL, 32'h0);
      axi_wr(8'h1c, 32'hdead_beef);
      axi_rd(8'h1c, rd);
      chk(rd, 32'h0);
      chk({30'h0, bresp}, 32'h0);
      chk({30'h0, rresp}, 32'h0);
      $display("Test registers done");
      // DLL on to off
      run_op(DFC_OP_ON2OFF);
      chk(sr_cnt - sr0, 1);
      chk({31'h0, dll_off}, 32'h1);
      $display("Test dll on to off done");
      // DLL off to on
      run_op(DFC_OP_OFF2ON);
      chk(sr_cnt - sr0, 1);
      chk({31'h0, dll_off}, 32'h0);
      chk(rst_cnt - rst0, 1);
      chk(zq_cnt - zq0, 1);
      $display("Test dll off to on done");
      // Clock change in precharge power-down
      run_op(DFC_OP_PDCHG);
      chk(sr_cnt - sr0, 0);
      chk(rst_cnt - rst0, 1);
      $display("Test power-down change done");
      // Write leveling from tap zero
      axi_wr(DFC_REG_WLDLY, 32'h0);
      run_op(DFC_OP_WLEV);
      chk({24'h0, dly}, TAP);
      chk({31'h0, wl_mode}, 32'h0);
      $display("Test write leveling done");
      // Protocol watch of the memory model
      chk(err_cnt, 0);
      give_verdict();
   end
endmodule
